/* File: rtl/vwc_decimator.sv */
// Purpose: temporal field/frame drop decision
// Assumes: one field start pulse per field, parity valid with it
// Notes:   drops spread evenly by a modulo accumulator
`timescale 1ns/1ns
`default_nettype none
module vwc_decimator
   import vwc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       field_start_i,
   input  wire logic       field_even_i,
   input  wire logic       is_625_i,
   input  wire logic [7:0] decim_i,
   output logic            field_drop_o
);
   vwc_dec_state_type state_r;
   vwc_dec_state_type state_nxt;
   logic [6:0] acc_r;
   logic [6:0] acc_nxt;
   logic       drop_r;
   logic       drop_nxt;
   logic       second_r;
   logic       second_nxt;
   logic [6:0] period;
   logic [6:0] count;
   logic [6:0] sum;
   logic       unit_by_field;
   logic       parity_ok;

   assign period        = is_625_i ? VWC_PERIOD_625 : VWC_PERIOD_525;
   assign count         = {1'b0, decim_i[5:0]};
   assign unit_by_field = decim_i[VWC_DEC_UNIT_BIT];
   assign parity_ok     = field_even_i == decim_i[VWC_DEC_PAR_BIT];

   always_comb begin
      state_nxt  = state_r;
      acc_nxt    = acc_r;
      drop_nxt   = drop_r;
      second_nxt = second_r;
      // preload so the first unit after alignment is dropped
      sum        = 7'(acc_r + count);
      if (state_r != VWC_DEC_RUN) begin
         sum = period;
      end
      if (field_start_i) begin
         case (state_r)
            VWC_DEC_IDLE, VWC_DEC_WAIT, VWC_DEC_RUN: begin
               if (count == 7'h00) begin
                  state_nxt = VWC_DEC_WAIT;
                  drop_nxt  = 1'b0;
               end else if (state_r != VWC_DEC_RUN && !parity_ok) begin
                  state_nxt = VWC_DEC_WAIT;
                  drop_nxt  = 1'b0;
               end else if (!unit_by_field && second_r && state_r == VWC_DEC_RUN) begin
                  second_nxt = 1'b0;
               end else begin
                  state_nxt  = VWC_DEC_RUN;
                  second_nxt = ~unit_by_field;
                  drop_nxt   = sum >= period;
                  acc_nxt    = (sum >= period) ? 7'(sum - period) : sum;
               end
            end
            default: begin
               state_nxt = VWC_DEC_WAIT;
               drop_nxt  = 1'b0;
            end
         endcase
         if (count == 7'h00 || state_nxt != VWC_DEC_RUN) begin
            second_nxt = 1'b0;
            acc_nxt    = 7'h00;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= VWC_DEC_IDLE;
         acc_r    <= 7'h00;
         drop_r   <= 1'b0;
         second_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         acc_r    <= acc_nxt;
         drop_r   <= drop_nxt;
         second_r <= second_nxt;
      end
   end

   assign field_drop_o = drop_r;
endmodule
`default_nettype wire

/* File: rtl/vwc_line_filter.sv */
// Purpose: debounced 525/625 line-count status
// Assumes: field_625_i valid at the field start pulse
// Notes:   status flips only after a full run of disagreeing fields
`timescale 1ns/1ns
`default_nettype none
module vwc_line_filter
   import vwc_pkg::*;
#(
   parameter int RUN = VWC_LINE_COUNT_STATUS_RUN
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic field_start_i,
   input  wire logic field_625_i,
   output logic      line_count_status_o
);
   logic [5:0] run_r;
   logic       status_r;
   logic       differ;
   logic       run_done;

   assign differ   = field_start_i && (field_625_i != status_r);
   assign run_done = differ && (run_r == 6'(RUN - 1));

   // ==========================================
   // 32 field debounce
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         run_r    <= 6'h00;
         status_r <= 1'b0;
      end else if (run_done) begin
         run_r    <= 6'h00;
         status_r <= ~status_r;
      end else if (differ) begin
         run_r <= run_r + 6'h01;
      end else if (field_start_i) begin
         run_r <= 6'h00;
      end
   end

   assign line_count_status_o = status_r;
endmodule
`default_nettype wire

/* File: rtl/vwc_pkg.sv */
// Purpose: constants and types of the video input window control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   reset table is indexed by offset minus first offset
package vwc_pkg;

   // ==========================================
   // register map
   localparam logic [7:0] VWC_ADDR_FORMAT  = 8'h01;
   localparam logic [7:0] VWC_ADDR_DECIM   = 8'h02;
   localparam logic [7:0] VWC_ADDR_UPPER   = 8'h03;
   localparam logic [7:0] VWC_ADDR_VDLY_LO = 8'h04;
   localparam logic [7:0] VWC_ADDR_VACT_LO = 8'h05;
   localparam logic [7:0] VWC_ADDR_HDLY_LO = 8'h06;
   localparam logic [7:0] VWC_ADDR_HACT_LO = 8'h07;
   localparam logic [7:0] VWC_ADDR_HRAT_HI = 8'h08;
   localparam logic [7:0] VWC_ADDR_HRAT_LO = 8'h09;
   localparam int         VWC_NUM_REGS     = 9;

   // ==========================================
   // reset values, entry 0 is offset 0x01
   localparam logic [8:0][7:0] VWC_RST_TABLE = {
      8'hac, 8'h02, 8'h80, 8'h78, 8'he0, 8'h16, 8'h12, 8'h00, 8'h58};

   // ==========================================
   // field positions
   localparam int VWC_HACT_EXT_BIT = 7;
   localparam int VWC_MUX_LSB      = 5;
   localparam int VWC_XT_LSB       = 3;
   localparam int VWC_FMT_LSB      = 0;
   localparam int VWC_DEC_UNIT_BIT = 7;
   localparam int VWC_DEC_PAR_BIT  = 6;
   localparam int VWC_VDLY_MSB_LSB = 6;
   localparam int VWC_VACT_MSB_LSB = 4;
   localparam int VWC_HDLY_MSB_LSB = 2;
   localparam int VWC_HACT_MSB_LSB = 0;

   // ==========================================
   // counts
   localparam int         VWC_LINE_COUNT_STATUS_RUN  = 32;
   localparam logic [6:0] VWC_PERIOD_525 = 7'h3c;
   localparam logic [6:0] VWC_PERIOD_625 = 7'h32;

   // ==========================================
   // codes
   typedef enum logic [2:0] {
      VWC_STD_AUTO  = 3'b000,
      VWC_STD_525P  = 3'b001,
      VWC_STD_525NP = 3'b010,
      VWC_STD_625   = 3'b011,
      VWC_STD_M     = 3'b100,
      VWC_STD_N     = 3'b101,
      VWC_STD_SEQ   = 3'b110,
      VWC_STD_NCOMB = 3'b111
   } vwc_std_type;

   typedef enum logic [1:0] {
      VWC_XT_RSVD = 2'b00,
      VWC_XT_0    = 2'b01,
      VWC_XT_1    = 2'b10,
      VWC_XT_AUTO = 2'b11
   } vwc_xtal_type;

   typedef enum logic [1:0] {
      VWC_DEC_IDLE = 2'b00,
      VWC_DEC_WAIT = 2'b01,
      VWC_DEC_RUN  = 2'b10
   } vwc_dec_state_type;

   typedef struct packed {
      logic [9:0]  vstart;
      logic [9:0]  vlines;
      logic [9:0]  hstart;
      logic [9:0]  hcount;
      logic [15:0] ratio;
   } vwc_window_type;

endpackage

/* File: rtl/vwc_top.sv */
// Purpose: register bank and window timing of the video input path
// Assumes: register port driven by the two-wire bus engine, same clock
// Notes:   window values take effect at the next field start
//
// How it works
// - format register is read/write any time, resets to 0x58.
// - bit 7 low ends active flag at line sync; high lets it run on.
// - input select 00->in3, 01->in2, 10->in0 default, 11->in1.
// - in auto mode the line-count status picks the decoded standard.
// - decimation register resets to 0; bit 7 frames (0) or fields (1).
// - bit 6 picks odd (0) or even (1) field as first dropped.
// - six-bit count drops out of 60 or 50; zero disables dropping.
// - upper bits register resets 0x12, holds four two-bit fields.
// - ten-bit vertical delay counts half lines after field sync.
// - ten-bit vertical active gives lines fed to scaling, low 0xE0.
// - ten-bit horizontal delay counts scaled pixels after line sync.
// - ten-bit horizontal active is pixels per line, low byte 0x80.
// - horizontal pixels are counted from the fall of line sync.
// - sixteen-bit horizontal ratio, high resets 0x02, low 0xAC.
// - line status flips after 32 fields in a row disagree with it; 0 525, 1 625.
`timescale 1ns/1ns
`default_nettype none
module vwc_top
   import vwc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   input  wire logic       field_sync_n_i,
   input  wire logic       line_sync_n_i,
   input  wire logic       half_line_i,
   input  wire logic       pixel_i,
   input  wire logic       field_even_i,
   input  wire logic       field_625_i,
   output logic            line_count_status_o,
   output logic [1:0]      video_input_select_o,
   output logic            crystal_choice_o,
   output vwc_std_type     decode_standard_o,
   output vwc_window_type  window_o,
   output logic            horizontal_active_o,
   output logic            vertical_active_o,
   output logic            field_drop_o
);

   // ==========================================
   // analog input number for a select code
   function automatic logic [1:0] input_of(input logic [1:0] code);
      logic [1:0] num;
      num = 2'h0;
      case (code)
         2'b00:   num = 2'h3;
         2'b01:   num = 2'h2;
         2'b10:   num = 2'h0;
         default: num = 2'h1;
      endcase
      return num;
   endfunction

   // ==========================================
   // register file
   logic [8:0][7:0] regs_r;
   logic [7:0]      rdata_r;
   logic [7:0]      rdata_nxt;
   logic [3:0]      rd_idx;
   logic            rd_hit;

   genvar gi;
   generate
      for (gi = 0; gi < VWC_NUM_REGS; gi++) begin : g_reg
         logic wr_sel;
         assign wr_sel = reg_wr_i && (reg_addr_i == 8'(VWC_ADDR_FORMAT + gi));
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               regs_r[gi] <= VWC_RST_TABLE[gi];
            end else if (wr_sel) begin
               regs_r[gi] <= reg_wdata_i;
            end
         end
      end
   endgenerate

   assign rd_idx    = 4'(reg_addr_i - VWC_ADDR_FORMAT);
   assign rd_hit    = (reg_addr_i >= VWC_ADDR_FORMAT) && (reg_addr_i <= VWC_ADDR_HRAT_LO);
   // unmapped offsets read as zero
   assign rdata_nxt = rd_hit ? regs_r[rd_idx] : 8'h00;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata_o = rdata_r;

   // ==========================================
   // named fields
   logic [7:0]   fmt_reg;
   logic [7:0]   dec_reg;
   logic [7:0]   upper_reg;
   logic         hact_extend;
   logic [1:0]   mux_code;
   vwc_xtal_type xt_code;
   vwc_std_type  std_code;
   logic         line_count_status;
   vwc_window_type win_live;

   assign fmt_reg     = regs_r[VWC_ADDR_FORMAT - VWC_ADDR_FORMAT];
   assign dec_reg     = regs_r[VWC_ADDR_DECIM - VWC_ADDR_FORMAT];
   assign upper_reg   = regs_r[VWC_ADDR_UPPER - VWC_ADDR_FORMAT];
   assign hact_extend = fmt_reg[VWC_HACT_EXT_BIT];
   assign mux_code    = fmt_reg[VWC_MUX_LSB +: 2];
   assign xt_code     = vwc_xtal_type'(fmt_reg[VWC_XT_LSB +: 2]);
   assign std_code    = vwc_std_type'(fmt_reg[VWC_FMT_LSB +: 3]);

   // upper bits concatenated with low bytes
   assign win_live.vstart = {upper_reg[VWC_VDLY_MSB_LSB +: 2],
                             regs_r[VWC_ADDR_VDLY_LO - VWC_ADDR_FORMAT]};
   assign win_live.vlines = {upper_reg[VWC_VACT_MSB_LSB +: 2],
                             regs_r[VWC_ADDR_VACT_LO - VWC_ADDR_FORMAT]};
   assign win_live.hstart = {upper_reg[VWC_HDLY_MSB_LSB +: 2],
                             regs_r[VWC_ADDR_HDLY_LO - VWC_ADDR_FORMAT]};
   assign win_live.hcount = {upper_reg[VWC_HACT_MSB_LSB +: 2],
                             regs_r[VWC_ADDR_HACT_LO - VWC_ADDR_FORMAT]};
   assign win_live.ratio  = {regs_r[VWC_ADDR_HRAT_HI - VWC_ADDR_FORMAT],
                             regs_r[VWC_ADDR_HRAT_LO - VWC_ADDR_FORMAT]};

   // ==========================================
   // input, crystal and standard selection
   // select code mapping
   assign video_input_select_o = input_of(mux_code);

   assign crystal_choice_o = (xt_code == VWC_XT_AUTO) ? line_count_status : (xt_code == VWC_XT_1);

   assign decode_standard_o = (std_code != VWC_STD_AUTO) ? std_code :
                              (line_count_status ? VWC_STD_625 : VWC_STD_525P);

   // ==========================================
   // sync edges
   logic field_prev_r;
   logic line_prev_r;
   logic field_start;
   logic line_fall;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         field_prev_r <= 1'b1;
         line_prev_r  <= 1'b1;
      end else begin
         field_prev_r <= field_sync_n_i;
         line_prev_r  <= line_sync_n_i;
      end
   end

   // trailing edge of the active-low field sync
   assign field_start = ~field_prev_r & field_sync_n_i;
   assign line_fall   = line_prev_r & ~line_sync_n_i;

   // ==========================================
   // shadow window
   vwc_window_type win_r;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         win_r <= {VWC_RST_TABLE[2][7:6], VWC_RST_TABLE[3],
                   VWC_RST_TABLE[2][5:4], VWC_RST_TABLE[4],
                   VWC_RST_TABLE[2][3:2], VWC_RST_TABLE[5],
                   VWC_RST_TABLE[2][1:0], VWC_RST_TABLE[6],
                   VWC_RST_TABLE[7], VWC_RST_TABLE[8]};
      end else if (field_start) begin
         win_r <= win_live;
      end
   end
   assign window_o = win_r;

   // ==========================================
   // horizontal window
   logic [9:0] hpos_r;
   logic [9:0] hrem_r;
   logic       hpos_full;
   logic       hstart_hit;

   assign hpos_full  = hpos_r == 10'h3ff;
   assign hstart_hit = pixel_i && (hpos_r == win_r.hstart);

   // pixel count restarts at line sync fall
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         hpos_r <= 10'h000;
      end else if (line_fall) begin
         hpos_r <= 10'h000;
      end else if (pixel_i && !hpos_full) begin
         hpos_r <= hpos_r + 10'h001;
      end
   end

   // extend bit decides cut at line sync
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         hrem_r <= 10'h000;
      end else if (line_fall && !hact_extend) begin
         hrem_r <= 10'h000;
      end else if (hstart_hit && !line_fall) begin
         hrem_r <= win_r.hcount;
      end else if (pixel_i && hrem_r != 10'h000) begin
         hrem_r <= hrem_r - 10'h001;
      end
   end
   assign horizontal_active_o = hrem_r != 10'h000;

   // ==========================================
   // vertical window
   logic [9:0] vpos_r;
   logic [9:0] vrem_r;
   logic       vstart_hit;

   assign vstart_hit = half_line_i && (vpos_r == win_r.vstart);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         vpos_r <= 10'h000;
      end else if (field_start) begin
         vpos_r <= 10'h000;
      end else if (half_line_i && vpos_r != 10'h3ff) begin
         vpos_r <= vpos_r + 10'h001;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         vrem_r <= 10'h000;
      end else if (field_start) begin
         vrem_r <= 10'h000;
      end else if (vstart_hit) begin
         vrem_r <= win_r.vlines;
      end else if (line_fall && vrem_r != 10'h000) begin
         vrem_r <= vrem_r - 10'h001;
      end
   end
   assign vertical_active_o = vrem_r != 10'h000;

   // ==========================================
   // line status and decimation
   // debounced line status
   vwc_line_filter #(
      .RUN (VWC_LINE_COUNT_STATUS_RUN)
   ) u_filter (
      .clk_sys_i           (clk_sys_i),
      .rst_i               (rst_i),
      .field_start_i       (field_start),
      .field_625_i         (field_625_i),
      .line_count_status_o (line_count_status)
   );
   assign line_count_status_o = line_count_status;

   vwc_decimator u_decim (
      .clk_sys_i     (clk_sys_i),
      .rst_i         (rst_i),
      .field_start_i (field_start),
      .field_even_i  (field_even_i),
      .is_625_i      (line_count_status),
      .decim_i       (dec_reg),
      .field_drop_o  (field_drop_o)
   );

endmodule
`default_nettype wire

/* File: tb/test_video_input_window_control.sv */
// Purpose: self-checking bench for the window control block
// Assumes: inputs driven by non-blocking assignment on the rising edge
// Notes:   fields kept a few cycles long to keep the run short
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
   end
module test_video_input_window_control;
   import vwc_pkg::*;
   localparam logic [7:0] RST_EXP [9] = '{8'h58, 8'h00, 8'h12, 8'h16, 8'he0, 8'h78, 8'h80, 8'h02, 8'hac};
   localparam logic [7:0] WIN_VAL [7] = '{8'h90, 8'h33, 8'h44, 8'h04, 8'h05, 8'h12, 8'h34};
   localparam logic [1:0] SEL_EXP [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
   localparam logic [7:0] DEC_VAL [3] = '{8'h94, 8'hc7, 8'h05};
   localparam int         DEC_EXP [3] = '{20, 7, 10};
   localparam int         DEC_NF  [3] = '{60, 60, 120};
   logic           clk_sys_i = 1'b0;
   logic           rst_i     = 1'b1;
   logic [7:0]     addr      = 8'h00;
   logic           wr        = 1'b0;
   logic [7:0]     wd        = 8'h00;
   logic           fsn       = 1'b1;
   logic           lsn       = 1'b1;
   logic           pix       = 1'b0;
   logic           half      = 1'b0;
   logic           even      = 1'b0;
   logic           f625      = 1'b0;
   logic [7:0]     rdata;
   logic           status;
   logic [1:0]     sel;
   logic           xtal;
   vwc_std_type    std;
   vwc_window_type win;
   logic           hact;
   logic           vact;
   logic           drop;
   int             mismatches = 0;
   int             n_checks   = 0;
   int             hcnt       = 0;

   vwc_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd),
      .reg_rdata_o(rdata), .field_sync_n_i(fsn), .line_sync_n_i(lsn), .half_line_i(half), .pixel_i(pix),
      .field_even_i(even), .field_625_i(f625), .line_count_status_o(status), .video_input_select_o(sel),
      .crystal_choice_o(xtal), .decode_standard_o(std), .window_o(win), .horizontal_active_o(hact),
      .vertical_active_o(vact), .field_drop_o(drop));

   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (pix && hact) hcnt <= hcnt + 1;

   // ==========================================
   // port tasks
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wd   <= d;
      wr   <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK("rdata", e, rdata)
   endtask
   task automatic do_field(input logic ev, input logic f);
      @(posedge clk_sys_i);
      fsn <= 1'b0;
      @(posedge clk_sys_i);
      fsn  <= 1'b1;
      even <= ev;
      f625 <= f;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic do_line(input int n);
      @(posedge clk_sys_i);
      lsn <= 1'b0;
      @(posedge clk_sys_i);
      lsn <= 1'b1;
      repeat (n) begin
         @(posedge clk_sys_i);
         pix <= 1'b1;
         @(posedge clk_sys_i);
         pix <= 1'b0;
      end
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic do_half(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         half <= 1'b1;
         @(posedge clk_sys_i);
         half <= 1'b0;
      end
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // scenarios
   initial begin
      int k;
      int i;
      int drops;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      `CHK("standard", VWC_STD_525P, std)
      for (k = 0; k < 9; k++) rchk(8'(k + 1), RST_EXP[k]);
      wreg(8'h0a, 8'hff);
      rchk(8'h0a, 8'h00);
      rchk(8'h00, 8'h00);
      // window values wait for the field start
      for (k = 0; k < 7; k++) wreg(8'(k + 3), WIN_VAL[k]);
      for (k = 0; k < 7; k++) rchk(8'(k + 3), WIN_VAL[k]);
      `CHK("window", {10'h016, 10'h1e0, 10'h078, 10'h280, 16'h02ac}, win)
      do_field(1'b0, 1'b0);
      `CHK("window", {10'h233, 10'h144, 10'h004, 10'h005, 16'h1234}, win)
      i = hcnt;
      do_line(20);
      `CHK("pixels", 5, hcnt - i)
      wreg(VWC_ADDR_HACT_LO, 8'h64);
      do_field(1'b0, 1'b0);
      do_line(10);
      `CHK("horizontal_active_count", 1'b1, hact)
      do_line(0);
      `CHK("horizontal_active_count", 1'b0, hact)
      wreg(VWC_ADDR_FORMAT, 8'hd8);
      do_line(10);
      do_line(0);
      `CHK("horizontal_active_count", 1'b1, hact)
      // selection codes
      for (k = 0; k < 4; k++) begin
         wreg(VWC_ADDR_FORMAT, {1'b0, 2'(k), 2'b11, 3'b000});
         `CHK("input", SEL_EXP[k], sel)
         wreg(VWC_ADDR_FORMAT, {1'b0, 2'b10, 2'(k), 3'b001});
         `CHK("crystal", (k == 2) ? 1'b1 : 1'b0, xtal)
      end
      for (k = 0; k < 8; k++) begin
         wreg(VWC_ADDR_FORMAT, {5'h0b, 3'(k)});
         `CHK("standard", (k == 0) ? VWC_STD_525P : vwc_std_type'(k), std)
      end
      rchk(VWC_ADDR_FORMAT, 8'h5f);
      // decimation: zero first, one wrong-parity field, then a full period
      for (k = 0; k < 3; k++) begin
         wreg(VWC_ADDR_DECIM, 8'h00);
         do_field(1'b0, 1'b0);
         `CHK("drop", 1'b0, drop)
         wreg(VWC_ADDR_DECIM, DEC_VAL[k]);
         do_field(~DEC_VAL[k][6], 1'b0);
         `CHK("drop", 1'b0, drop)
         drops = 0;
         for (i = 0; i < DEC_NF[k]; i++) begin
            do_field(DEC_VAL[k][6] ^ i[0], 1'b0);
            if (i == 0) `CHK("drop", 1'b1, drop)
            drops += int'(drop === 1'b1);
         end
         `CHK("drops", DEC_EXP[k], drops)
      end
      rchk(VWC_ADDR_DECIM, 8'h05);
      // line status needs a full run of 625-line fields
      for (k = 0; k < 32; k++) begin
         if (k == 31) `CHK("status", 1'b0, status)
         do_field(1'b0, 1'b1);
      end
      `CHK("status", 1'b1, status)
      wreg(VWC_ADDR_FORMAT, 8'h58);
      `CHK("standard", VWC_STD_625, std)
      `CHK("crystal", 1'b1, xtal)
      // vertical window: two half lines of delay, three active lines
      wreg(VWC_ADDR_UPPER, 8'h00);
      wreg(VWC_ADDR_VDLY_LO, 8'h02);
      wreg(VWC_ADDR_VACT_LO, 8'h03);
      do_field(1'b0, 1'b1);
      do_half(2);
      `CHK("vertical_line_count", 1'b0, vact)
      do_half(1);
      `CHK("vertical_line_count", 1'b1, vact)
      do_line(0);
      do_line(0);
      `CHK("vertical_line_count", 1'b1, vact)
      do_line(0);
      `CHK("vertical_line_count", 1'b0, vact)
      results();
   end

   // cuts a hang well past the roughly 1650 cycles the run needs
   initial begin
      #200_000;
      mismatches++;
      results();
   end
endmodule
`default_nettype wire

/* File: tb/vwc_top_chk.sv */
// Purpose: port assertions for the window control register bank
// Assumes: one-cycle write strobe, read data one cycle behind offset
// Notes:   extend bit and status run rebuilt from port traffic
`timescale 1ns/1ns
`default_nettype none
module vwc_top_chk
   import vwc_pkg::*;
(
   input  wire logic           clk_sys_i,
   input  wire logic           rst_i,
   input  wire logic [7:0]     reg_addr_i,
   input  wire logic           reg_wr_i,
   input  wire logic [7:0]     reg_wdata_i,
   input  wire logic [7:0]     reg_rdata_o,
   input  wire logic           field_sync_n_i,
   input  wire logic           line_sync_n_i,
   input  wire logic           field_625_i,
   input  wire logic           line_count_status_o,
   input  wire logic [1:0]     video_input_select_o,
   input  wire logic           crystal_choice_o,
   input  wire vwc_std_type    decode_standard_o,
   input  wire vwc_window_type window_o,
   input  wire logic           horizontal_active_o,
   input  wire logic           field_drop_o
);
   // ==========================================
   // helper state
   logic       fsn_d_r;
   logic       lsn_d_r;
   logic       ext_r;
   logic [5:0] run_r;
   logic [7:0] wd_r;
   logic       fstart;
   logic       lfall;
   logic       fmt_wr;
   assign fstart = field_sync_n_i & ~fsn_d_r;
   assign lfall  = lsn_d_r & ~line_sync_n_i;
   assign fmt_wr = reg_wr_i & (reg_addr_i == VWC_ADDR_FORMAT);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         fsn_d_r <= 1'b1;
         lsn_d_r <= 1'b1;
         ext_r   <= 1'b0;
         run_r   <= 6'h00;
         wd_r    <= 8'h00;
      end else begin
         fsn_d_r <= field_sync_n_i;
         lsn_d_r <= line_sync_n_i;
         wd_r    <= reg_wdata_i;
         if (fmt_wr) ext_r <= reg_wdata_i[7];
         // an agreeing field breaks the run, so only a full run flips
         if (fstart) run_r <= (field_625_i == line_count_status_o || run_r == 6'h1f) ? 6'h00 : run_r + 6'h01;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   unmapped_read_a: assert property ((reg_addr_i == 8'h00 || reg_addr_i > 8'h09) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   reg_readback_a: assert property ((reg_wr_i && reg_addr_i >= 8'h01 && reg_addr_i <= 8'h09) ##1
      (!reg_wr_i && $stable(reg_addr_i)) |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback");
   input_select_a: assert property (fmt_wr |=> video_input_select_o == {~wd_r[6], wd_r[6] ~^ wd_r[5]})
      else $error("input select wrong");
   crystal_code_a: assert property (fmt_wr |=> crystal_choice_o ==
      ((wd_r[4:3] == 2'b11) ? line_count_status_o : (wd_r[4:3] == 2'b10))) else $error("crystal wrong");
   std_decode_a: assert property (fmt_wr |=> decode_standard_o == ((wd_r[2:0] != 3'b000) ?
      vwc_std_type'(wd_r[2:0]) : (line_count_status_o ? VWC_STD_625 : VWC_STD_525P))) else $error("standard");
   window_hold_a: assert property (!fstart |=> $stable(window_o))
      else $error("window changed mid field");
   hact_clear_a: assert property ((lfall && !ext_r) |=> !horizontal_active_o)
      else $error("active flag not cleared");
   drop_timing_a: assert property ($changed(field_drop_o) |-> $past(fstart))
      else $error("drop changed off field start");
   status_flip_a: assert property ($changed(line_count_status_o) |-> $past(fstart) && $past(run_r) == 6'h1f)
      else $error("status flip early");
endmodule

bind vwc_top vwc_top_chk chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .field_sync_n_i(field_sync_n_i),
   .line_sync_n_i(line_sync_n_i), .field_625_i(field_625_i), .line_count_status_o(line_count_status_o),
   .video_input_select_o(video_input_select_o), .crystal_choice_o(crystal_choice_o),
   .decode_standard_o(decode_standard_o), .window_o(window_o), .horizontal_active_o(horizontal_active_o),
   .field_drop_o(field_drop_o));
`default_nettype wire
